// ===== include/wlhs_flag_if.sv
/*
  Carrier between the status top and one bank of sticky fault flags.
  Assumes a single clock domain on both sides.
*/
`timescale 1ns/1ps
`default_nettype none

interface wlhs_flag_if;
  wlhs_pkg::wlhs_hs_t set;
  logic               clr_all;
  logic               rd_clr;
  wlhs_pkg::wlhs_hs_t flags;

  modport bank (
    input  set,
    input  clr_all,
    input  rd_clr,
    output flags
  );

  modport user (
    output set,
    output clr_all,
    output rd_clr,
    input  flags
  );
endinterface : wlhs_flag_if

`default_nettype wire

// ===== include/wlhs_map.svh
/*
  Offsets, field positions, reset values and mode codes of the wake level
  and high-side fault status block.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef WLHS_MAP_SVH
`define WLHS_MAP_SVH

// Register port
`define WLHS_ADDR_W         7
`define WLHS_DATA_W         16
`define WLHS_WAKE_LVL_ADDR  7'h45
`define WLHS_HS_FAULT_ADDR  7'h46

// Field sizes
`define WLHS_NUM_WAKE       5
`define WLHS_NUM_HS         4

// Wake level register layout
`define WLHS_WAKE_LSB       0
`define WLHS_WAKE_MSB       4
`define WLHS_WAKE_FREE_BIT  1
`define WLHS_WAKE_RST       5'h00

// High-side fault register layout
`define WLHS_OC_LSB         0
`define WLHS_OC_MSB         3
`define WLHS_OL_LSB         5
`define WLHS_OL_MSB         8
`define WLHS_OT_LSB         10
`define WLHS_OT_MSB         13
`define WLHS_HS_RST         4'h0
`define WLHS_WORD_RST       16'h0000

// Device mode codes
`define WLHS_MODE_INIT      3'h0
`define WLHS_MODE_NORMAL    3'h1
`define WLHS_MODE_STOP      3'h2
`define WLHS_MODE_SLEEP     3'h3
`define WLHS_MODE_RESTART   3'h4
`define WLHS_MODE_FAILSAFE  3'h5

`endif

// ===== include/wlhs_pkg.sv
/*
  Types shared by the wake level and high-side fault status block.
  Assumes wlhs_map.svh is on the include path.
*/
`include "wlhs_map.svh"

package wlhs_pkg;
  typedef logic [2:0]                  wlhs_mode_t;
  typedef logic [`WLHS_ADDR_W-1:0]     wlhs_addr_t;
  typedef logic [`WLHS_DATA_W-1:0]     wlhs_word_t;
  typedef logic [`WLHS_NUM_WAKE-1:0]   wlhs_wake_t;
  typedef logic [`WLHS_NUM_HS-1:0]     wlhs_hs_t;
  typedef enum {
    WLHS_SEL_NONE,
    WLHS_SEL_WAKE,
    WLHS_SEL_HS
  } wlhs_rsel_t;
endpackage : wlhs_pkg

// ===== logic/wlhs_flag_bank.sv
/*
  One bank of sticky fault flags, cleared when read or by soft reset.
  Assumes set pulses or levels come from logic on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wlhs_map.svh"

module wlhs_flag_bank (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // Flag carrier
  wlhs_flag_if.bank fb
);

  // Set beats read-clear so a persisting fault survives the read
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fb.flags <= `WLHS_HS_RST;
    end else if (fb.clr_all) begin
      fb.flags <= `WLHS_HS_RST;
    end else begin
      fb.flags <= (fb.flags & ~{`WLHS_NUM_HS{fb.rd_clr}}) | fb.set;
    end
  end

endmodule : wlhs_flag_bank

`default_nettype wire

// ===== logic/wlhs_status_top.sv
/*
  Wake input level register and high-side fault status register, read
  through a plain register read port behind the serial interface.
  Assumes the serial frame logic issues one-cycle read strobes on core_clk,
  mode, reset events and fault detections come from core_clk logic, and
  the wake pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wlhs_map.svh"

// Overview of operation
// - Entering fail-safe mode clears all wake-source flags by itself.
// - The wake level register shows wake inputs five to one on bits 4 to 0, high as 1.
// - Reserved bits of both registers always read as zero.
// - The wake level register keeps updating in normal, stop, init and restart modes.
// - Under cyclic sense or cyclic wake the register holds the sampled level.
// - Under cyclic sense or cyclic wake the register refreshes after every sampling in normal, stop, init and restart modes.
// - After power-on the wake level reads zero; after soft reset or restart it reads zero except bit 1.
// - Overtemperature flags of switches four to one latch on bits 13 to 10, clear on read.
// - Open-load flags of switches four to one latch on bits 8 to 5, clear on read.
// - Overcurrent flags of switches four to one latch on bits 3 to 0, clear on read.
// - Soft reset clears the whole fault register; restart keeps bits 13 to 0.
module wlhs_status_top (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  // Reset events
  input  wire logic                 soft_reset,
  input  wire logic                 restart,
  // Device mode and cyclic sampling
  input  wire wlhs_pkg::wlhs_mode_t dev_mode,
  input  wire logic                 cyclic_en,
  input  wire logic                 cyclic_sample,
  // Wake pins
  input  wire wlhs_pkg::wlhs_wake_t wake_pin,
  // High-side fault detections
  input  wire wlhs_pkg::wlhs_hs_t   hs_overtemp_det,
  input  wire wlhs_pkg::wlhs_hs_t   hs_open_load_det,
  input  wire wlhs_pkg::wlhs_hs_t   hs_overcurrent_det,
  // Register read port
  input  wire logic                 reg_rd,
  input  wire wlhs_pkg::wlhs_addr_t reg_addr,
  output var  wlhs_pkg::wlhs_word_t reg_rdata,
  output var  logic                 reg_rvalid,
  output var  logic                 reg_hit,
  // Wake-source register control
  output var  logic                 wake_source_clear,
  // Status for other blocks
  output var  wlhs_pkg::wlhs_wake_t wake_level,
  output var  logic                 hs_fault_any
);

  // Synchronised wake pins
  wlhs_pkg::wlhs_wake_t wake_sync;

  // Mode tracking
  wlhs_pkg::wlhs_mode_t prev_mode;
  logic                 mode_updates;
  logic                 failsafe_entry;

  // Wake level state
  wlhs_pkg::wlhs_wake_t wake_input_level_status;
  wlhs_pkg::wlhs_wake_t next_wake_level;
  logic                 wake_load;
  logic                 wake_reinit;

  // Read decode
  wlhs_pkg::wlhs_rsel_t rsel;
  logic                 hs_read;

  // Fault flags and register images
  wlhs_pkg::wlhs_hs_t   ot_flags;
  wlhs_pkg::wlhs_hs_t   ol_flags;
  wlhs_pkg::wlhs_hs_t   oc_flags;
  wlhs_pkg::wlhs_word_t wake_word;
  wlhs_pkg::wlhs_word_t high_side_fault_status;

  // Flag carriers
  wlhs_flag_if ot_if ();
  wlhs_flag_if ol_if ();
  wlhs_flag_if oc_if ();

  wlhs_sync #(
    .W (`WLHS_NUM_WAKE)
  ) u_wake_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in (wake_pin),
    .sync_out (wake_sync)
  );

  // Mode decode
  always_comb begin
    unique case (dev_mode)
      `WLHS_MODE_NORMAL,
      `WLHS_MODE_STOP,
      `WLHS_MODE_INIT,
      `WLHS_MODE_RESTART: mode_updates = 1'b1;
      default:            mode_updates = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prev_mode <= `WLHS_MODE_INIT;
    end else begin
      prev_mode <= dev_mode;
    end
  end

  assign failsafe_entry = (dev_mode == `WLHS_MODE_FAILSAFE) &&
                          (prev_mode != `WLHS_MODE_FAILSAFE);

  // One pulse per entry, no software access needed
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wake_source_clear <= 1'b0;
    end else begin
      wake_source_clear <= failsafe_entry;
    end
  end

  // Wake level update
  // Cyclic mode loads only on a sample strobe, so the register holds
  // the sampled level even while the pins move between samples
  assign wake_load   = mode_updates && (!cyclic_en || cyclic_sample);
  assign wake_reinit = soft_reset || restart;

  always_comb begin
    next_wake_level = wake_input_level_status;
    if (wake_reinit) begin
      next_wake_level = `WLHS_WAKE_RST;
      next_wake_level[`WLHS_WAKE_FREE_BIT] = wake_sync[`WLHS_WAKE_FREE_BIT];
    end else if (wake_load) begin
      next_wake_level = wake_sync;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wake_input_level_status <= `WLHS_WAKE_RST;
    end else begin
      wake_input_level_status <= next_wake_level;
    end
  end

  // Read decode
  always_comb begin
    if (!reg_rd) begin
      rsel = wlhs_pkg::WLHS_SEL_NONE;
    end else if (reg_addr == `WLHS_WAKE_LVL_ADDR) begin
      rsel = wlhs_pkg::WLHS_SEL_WAKE;
    end else if (reg_addr == `WLHS_HS_FAULT_ADDR) begin
      rsel = wlhs_pkg::WLHS_SEL_HS;
    end else begin
      rsel = wlhs_pkg::WLHS_SEL_NONE;
    end
  end

  assign hs_read = (rsel == wlhs_pkg::WLHS_SEL_HS);

  // Fault flag banks
  // Restart leaves the flags alone; only soft reset and power-on reset wipe them
  assign ot_if.set     = hs_overtemp_det;
  assign ot_if.clr_all = soft_reset;
  assign ot_if.rd_clr  = hs_read;
  assign ol_if.set     = hs_open_load_det;
  assign ol_if.clr_all = soft_reset;
  assign ol_if.rd_clr  = hs_read;
  assign oc_if.set     = hs_overcurrent_det;
  assign oc_if.clr_all = soft_reset;
  assign oc_if.rd_clr  = hs_read;

  wlhs_flag_bank u_ot_bank (
    .core_clk (core_clk),
    .rstn     (rstn),
    .fb       (ot_if.bank)
  );

  wlhs_flag_bank u_ol_bank (
    .core_clk (core_clk),
    .rstn     (rstn),
    .fb       (ol_if.bank)
  );

  wlhs_flag_bank u_oc_bank (
    .core_clk (core_clk),
    .rstn     (rstn),
    .fb       (oc_if.bank)
  );

  assign ot_flags = ot_if.flags;
  assign ol_flags = ol_if.flags;
  assign oc_flags = oc_if.flags;

  // Register images
  always_comb begin
    wake_word = `WLHS_WORD_RST;
    wake_word[`WLHS_WAKE_MSB:`WLHS_WAKE_LSB] = wake_input_level_status;
  end

  always_comb begin
    high_side_fault_status = `WLHS_WORD_RST;
    high_side_fault_status[`WLHS_OT_MSB:`WLHS_OT_LSB] = ot_flags;
    high_side_fault_status[`WLHS_OL_MSB:`WLHS_OL_LSB] = ol_flags;
    high_side_fault_status[`WLHS_OC_MSB:`WLHS_OC_LSB] = oc_flags;
  end

  // Read data captured in the strobe cycle, before the clear lands
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= `WLHS_WORD_RST;
    end else if (reg_rd) begin
      unique case (rsel)
        wlhs_pkg::WLHS_SEL_WAKE: reg_rdata <= wake_word;
        wlhs_pkg::WLHS_SEL_HS:   reg_rdata <= high_side_fault_status;
        wlhs_pkg::WLHS_SEL_NONE: reg_rdata <= `WLHS_WORD_RST;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rvalid <= 1'b0;
      reg_hit    <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_hit    <= (rsel != wlhs_pkg::WLHS_SEL_NONE);
    end
  end

  // Status for other blocks
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wake_level   <= `WLHS_WAKE_RST;
      hs_fault_any <= 1'b0;
    end else begin
      wake_level   <= wake_input_level_status;
      hs_fault_any <= |{ot_flags, ol_flags, oc_flags};
    end
  end

endmodule : wlhs_status_top

`default_nettype wire

// ===== logic/wlhs_sync.sv
/*
  Two-stage synchroniser for a group of asynchronous levels.
  Assumes inputs are independent levels; no word coherence is given.
*/
`timescale 1ns/1ps
`default_nettype none

module wlhs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // Levels
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // Only the second stage reads the first
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : wlhs_sync

`default_nettype wire

// ===== test/tb_wlhs_status_top.sv
/*
  Self-checking bench for the wake level and fault status top.
  Assumes package, interface and design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_wlhs_status_top;
  logic                 core_clk, rstn, soft_reset, restart, cyclic_en, cyclic_sample, reg_rd;
  logic                 reg_rvalid, reg_hit, wake_source_clear, hs_fault_any;
  wlhs_pkg::wlhs_mode_t dev_mode;
  wlhs_pkg::wlhs_wake_t wake_pin, wake_level;
  wlhs_pkg::wlhs_hs_t   ot, ol, oc;
  wlhs_pkg::wlhs_addr_t reg_addr;
  wlhs_pkg::wlhs_word_t reg_rdata;
  int                   mismatches = 0, checks_done = 0, cyc = 0, n;

  wlhs_status_top uut (.core_clk, .rstn, .soft_reset, .restart, .dev_mode, .cyclic_en, .cyclic_sample,
    .wake_pin, .hs_overtemp_det(ot), .hs_open_load_det(ol), .hs_overcurrent_det(oc), .reg_rd, .reg_addr,
    .reg_rdata, .reg_rvalid, .reg_hit, .wake_source_clear, .wake_level, .hs_fault_any);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic t(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : t

  task automatic cmp(input wlhs_pkg::wlhs_word_t got, input wlhs_pkg::wlhs_word_t exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp

  // Holding the strobe lets reads run back to back without a double drive
  task automatic rd(input wlhs_pkg::wlhs_addr_t a, input wlhs_pkg::wlhs_word_t e, input bit h);
    reg_addr = a;
    reg_rd   = 1'b1;
    t(1);
    cmp(reg_rdata, e);
    cmp({14'h0000, reg_rvalid, reg_hit}, {14'h0000, 1'b1, a inside {7'h45, 7'h46}});
    if (!h) begin
      reg_rd = 1'b0;
      t(1);
    end
  endtask : rd

  task automatic results;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // Whole sequence needs some 95 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    {rstn, soft_reset, restart, cyclic_en, cyclic_sample, reg_rd} = '0;
    {dev_mode, wake_pin, ot, ol, oc, reg_addr} = '0;
    t(8);
    rstn = 1'b1;
    t(4);
    rd(7'h45, 16'h0000, 0);
    rd(7'h46, 16'h0000, 0);
    rd(7'h47, 16'h0000, 0);
    dev_mode = 3'h1;
    wake_pin = 5'h15;
    t(5);
    rd(7'h45, 16'h0015, 0);
    cmp({11'h000, wake_level}, 16'h0015);
    dev_mode = 3'h2;
    wake_pin = 5'h17;
    t(5);
    rd(7'h45, 16'h0017, 0);
    {ot, ol, oc} = {4'h9, 4'h6, 4'hF};
    t(1);
    {ot, ol, oc} = '0;
    rd(7'h46, 16'h24CF, 1);
    cmp({15'h0000, hs_fault_any}, 16'h0001);
    rd(7'h46, 16'h0000, 0);
    cmp({15'h0000, hs_fault_any}, 16'h0000);
    oc = 4'h2;
    rd(7'h46, 16'h0000, 1);
    oc = '0;
    rd(7'h46, 16'h0002, 1);
    rd(7'h46, 16'h0000, 0);
    ol = 4'h8;
    t(1);
    ol = '0;
    restart = 1'b1;
    t(1);
    restart = 1'b0;
    rd(7'h46, 16'h0100, 0);
    oc = 4'h4;
    t(1);
    oc = '0;
    soft_reset = 1'b1;
    t(1);
    soft_reset = 1'b0;
    rd(7'h46, 16'h0000, 0);
    // Sleep freezes the register, so the restart value can be read at leisure
    dev_mode = 3'h3;
    restart = 1'b1;
    t(1);
    restart = 1'b0;
    rd(7'h45, 16'h0002, 0);
    wake_pin = 5'h08;
    t(5);
    rd(7'h45, 16'h0002, 0);
    dev_mode = 3'h1;
    cyclic_en = 1'b1;
    t(5);
    rd(7'h45, 16'h0002, 0);
    cyclic_sample = 1'b1;
    t(1);
    cyclic_sample = 1'b0;
    rd(7'h45, 16'h0008, 0);
    dev_mode = 3'h5;
    n = 0;
    repeat (4) begin
      t(1);
      if (wake_source_clear === 1'b1) n++;
    end
    cmp(16'(n), 16'h0001);
    // Fail-safe holds the level even when a cyclic sample arrives
    wake_pin = 5'h1F;
    t(4);
    cyclic_sample = 1'b1;
    t(1);
    cyclic_sample = 1'b0;
    rd(7'h45, 16'h0008, 0);
    {dev_mode, cyclic_en} = {3'h4, 1'b0};
    t(1);
    rd(7'h45, 16'h001F, 0);
    // Two synchroniser edges, then the load edge
    {dev_mode, wake_pin} = {3'h0, 5'h04};
    t(2);
    rd(7'h45, 16'h001F, 1);
    rd(7'h45, 16'h0004, 0);
    cmp({11'h000, wake_level}, 16'h0004);
    // Mid-run power-on reset wipes a latched flag
    ot = 4'h1;
    t(1);
    ot = '0;
    t(1);
    cmp({15'h0000, hs_fault_any}, 16'h0001);
    rstn = 1'b0;
    t(2);
    rstn = 1'b1;
    rd(7'h45, 16'h0000, 1);
    rd(7'h46, 16'h0000, 0);
    results();
  end
endmodule : tb_wlhs_status_top

bind wlhs_status_top wlhs_status_monitor mon (.core_clk, .rstn, .soft_reset, .dev_mode, .hs_overtemp_det,
  .hs_open_load_det, .hs_overcurrent_det, .reg_rd, .reg_addr, .reg_rdata, .reg_rvalid, .reg_hit,
  .wake_source_clear);

`default_nettype wire

// ===== test/wlhs_status_monitor.sv
/*
  Assertions on the ports of the wake level and fault status top.
  Assumes a bind onto wlhs_status_top and a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module wlhs_status_monitor (
  // Clock and reset
  input wire logic                 core_clk,
  input wire logic                 rstn,
  // Causes
  input wire logic                 soft_reset,
  input wire wlhs_pkg::wlhs_mode_t dev_mode,
  input wire wlhs_pkg::wlhs_hs_t   hs_overtemp_det,
  input wire wlhs_pkg::wlhs_hs_t   hs_open_load_det,
  input wire wlhs_pkg::wlhs_hs_t   hs_overcurrent_det,
  input wire logic                 reg_rd,
  input wire wlhs_pkg::wlhs_addr_t reg_addr,
  // Answers
  input wire wlhs_pkg::wlhs_word_t reg_rdata,
  input wire logic                 reg_rvalid,
  input wire logic                 reg_hit,
  input wire logic                 wake_source_clear
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence rd_wake; reg_rd && reg_addr == 7'h45; endsequence
  sequence rd_hs; reg_rd && reg_addr == 7'h46; endsequence
  // Detections made under reset or soft reset never latch
  sequence rd_hs_set; rd_hs ##0 ($past(rstn) && !$past(soft_reset)); endsequence
  sequence fs_entry; dev_mode == 3'h5 && $past(dev_mode) != 3'h5; endsequence
  // A clearing read with no detection present in its own cycle
  sequence rd_hs_quiet; rd_hs ##0 (hs_overtemp_det | hs_open_load_det | hs_overcurrent_det) == 4'h0; endsequence

  read_answer_a: assert property (reg_rd |=> reg_rvalid && reg_hit == $past(reg_addr inside {7'h45, 7'h46}))
    else $error("read answer wrong");
  wake_reserved_a: assert property (rd_wake |=> reg_rdata[15:5] == 11'h000)
    else $error("wake reserved bits set");
  hs_reserved_a: assert property (rd_hs |=> {reg_rdata[15:14], reg_rdata[9], reg_rdata[4]} == 4'h0)
    else $error("fault reserved bits set");
  ot_latch_a: assert property (rd_hs_set |=>
    (reg_rdata[13:10] & $past(hs_overtemp_det, 2)) == $past(hs_overtemp_det, 2))
    else $error("overtemp flag lost");
  ol_latch_a: assert property (rd_hs_set |=>
    (reg_rdata[8:5] & $past(hs_open_load_det, 2)) == $past(hs_open_load_det, 2))
    else $error("open load flag lost");
  oc_latch_a: assert property (rd_hs_set |=>
    (reg_rdata[3:0] & $past(hs_overcurrent_det, 2)) == $past(hs_overcurrent_det, 2))
    else $error("overcurrent flag lost");
  read_clears_a: assert property (rd_hs_quiet ##1 rd_hs |=> reg_rdata == 16'h0000)
    else $error("flag not cleared by read");
  fs_clear_a: assert property (fs_entry |=> wake_source_clear ##1 !wake_source_clear)
    else $error("fail-safe clear pulse wrong");
endmodule : wlhs_status_monitor

`default_nettype wire
